// file: core/adc_window_pkg.sv
package adc_window_pkg;
   localparam int RESULT_W = 10;
   localparam logic [7:0] ADDR_CTRL = 8'hE8;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBF;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'hBE;
   localparam logic [7:0] ADDR_GREATER_HIGH = 8'hC5;
   localparam logic [7:0] ADDR_GREATER_LOW = 8'hC4;
   localparam logic [7:0] ADDR_LESS_HIGH = 8'hC7;
   localparam logic [7:0] ADDR_LESS_LOW = 8'hC6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] GREATER_RESET = 8'hFF;
   localparam logic [7:0] LESS_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int CTRL_FLAG_BIT = 1;
   localparam int CTRL_LJUST_BIT = 0;
endpackage

// file: core/result_format_if.sv
`timescale 1ns/1ps
interface result_format_if;
   logic [adc_window_pkg::RESULT_W-1:0] raw;
   logic left_justify;
   logic differential;
   logic [15:0] word;
   modport user (output raw, output left_justify, output differential,
      input word);
   modport formatter (input raw, input left_justify, input differential,
      output word);
endinterface

// file: core/result_formatter.sv
`timescale 1ns/1ps
module result_formatter (
   result_format_if.formatter fmt
);
   always_comb begin
      if (fmt.left_justify) begin
         fmt.word = {fmt.raw, 6'h00};
      end else if (fmt.differential) begin
         fmt.word = {{6{fmt.raw[9]}}, fmt.raw};
      end else begin
         fmt.word = {6'h00, fmt.raw};
      end
   end
endmodule

// file: core/adc_result_window_detect.sv
`timescale 1ns/1ps
module adc_result_window_detect (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic result_valid_i,
   input wire logic [adc_window_pkg::RESULT_W-1:0] result_data_i,
   input wire logic differential_i,
   output logic [7:0] sfr_rdata_o,
   output logic window_compare_flag_o,
   output logic result_left_justify_o
);
   logic [7:0] converter_control_reg;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   logic [7:0] window_greater_high_byte;
   logic [7:0] window_greater_low_byte;
   logic [7:0] window_less_high_byte;
   logic [7:0] window_less_low_byte;
   logic [7:0] next_converter_control_reg;
   logic [7:0] next_result_high_byte;
   logic [7:0] next_result_low_byte;
   logic [7:0] next_window_greater_high_byte;
   logic [7:0] next_window_greater_low_byte;
   logic [7:0] next_window_less_high_byte;
   logic [7:0] next_window_less_low_byte;
   logic [7:0] next_rdata;
   logic above_greater;
   logic below_less;
   logic window_hit;
   logic [15:0] greater_word;
   logic [15:0] less_word;
   logic less_above_greater;
   logic ctrl_write;
   logic result_high_write;
   logic result_low_write;
   logic greater_high_write;
   logic greater_low_write;
   logic less_high_write;
   logic less_low_write;

   result_format_if fmt ();

   result_formatter u_formatter (
      .fmt(fmt.formatter)
   );

   // Signed compare flips the sign bit so one unsigned compare serves both
   function automatic logic word_above(input logic [15:0] a,
      input logic [15:0] b, input logic is_signed);
      logic [15:0] ka;
      logic [15:0] kb;
      ka = {a[15] ^ is_signed, a[14:0]};
      kb = {b[15] ^ is_signed, b[14:0]};
      return ka > kb;
   endfunction

   // Strobe is an argument so every caller stays sensitive to it
   function automatic logic write_to(input logic strobe,
      input logic [7:0] addr, input logic [7:0] target);
      return strobe && addr == target;
   endfunction

   assign fmt.raw = result_data_i;
   assign fmt.left_justify =
      converter_control_reg[adc_window_pkg::CTRL_LJUST_BIT];
   assign fmt.differential = differential_i;
   assign greater_word = {window_greater_high_byte, window_greater_low_byte};
   assign less_word = {window_less_high_byte, window_less_low_byte};

   assign ctrl_write = write_to(sfr_wr_i, sfr_addr_i,
      adc_window_pkg::ADDR_CTRL);
   assign result_high_write = write_to(sfr_wr_i, sfr_addr_i,
      adc_window_pkg::ADDR_RESULT_HIGH);
   assign result_low_write = write_to(sfr_wr_i, sfr_addr_i,
      adc_window_pkg::ADDR_RESULT_LOW);
   assign greater_high_write = write_to(sfr_wr_i, sfr_addr_i,
      adc_window_pkg::ADDR_GREATER_HIGH);
   assign greater_low_write = write_to(sfr_wr_i, sfr_addr_i,
      adc_window_pkg::ADDR_GREATER_LOW);
   assign less_high_write = write_to(sfr_wr_i, sfr_addr_i,
      adc_window_pkg::ADDR_LESS_HIGH);
   assign less_low_write = write_to(sfr_wr_i, sfr_addr_i,
      adc_window_pkg::ADDR_LESS_LOW);

   always_comb begin
      // Limits are taken as already in the result's own format
      above_greater = word_above(fmt.word, greater_word,
         differential_i);
      below_less = word_above(less_word, fmt.word,
         differential_i);
      less_above_greater = word_above(less_word, greater_word,
         differential_i);
      // Less above greater gives an inside window, otherwise outside
      if (less_above_greater) begin
         window_hit = result_valid_i && above_greater && below_less;
      end else begin
         window_hit = result_valid_i && (above_greater || below_less);
      end
   end

   always_comb begin
      next_window_greater_high_byte = window_greater_high_byte;
      next_window_greater_low_byte = window_greater_low_byte;
      next_window_less_high_byte = window_less_high_byte;
      next_window_less_low_byte = window_less_low_byte;
      if (greater_high_write) begin
         next_window_greater_high_byte = sfr_wdata_i;
      end
      if (greater_low_write) begin
         next_window_greater_low_byte = sfr_wdata_i;
      end
      if (less_high_write) begin
         next_window_less_high_byte = sfr_wdata_i;
      end
      if (less_low_write) begin
         next_window_less_low_byte = sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         window_greater_high_byte <= adc_window_pkg::GREATER_RESET;
         window_greater_low_byte <= adc_window_pkg::GREATER_RESET;
         window_less_high_byte <= adc_window_pkg::LESS_RESET;
         window_less_low_byte <= adc_window_pkg::LESS_RESET;
      end else begin
         window_greater_high_byte <= next_window_greater_high_byte;
         window_greater_low_byte <= next_window_greater_low_byte;
         window_less_high_byte <= next_window_less_high_byte;
         window_less_low_byte <= next_window_less_low_byte;
      end
   end

   // A fresh result overrides a software write in the same cycle
   always_comb begin
      next_result_high_byte = result_high_byte;
      next_result_low_byte = result_low_byte;
      if (result_valid_i) begin
         next_result_high_byte = fmt.word[15:8];
         next_result_low_byte = fmt.word[7:0];
      end else begin
         if (result_high_write) begin
            next_result_high_byte = sfr_wdata_i;
         end
         if (result_low_write) begin
            next_result_low_byte = sfr_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         result_high_byte <= adc_window_pkg::RESULT_RESET;
         result_low_byte <= adc_window_pkg::RESULT_RESET;
      end else begin
         result_high_byte <= next_result_high_byte;
         result_low_byte <= next_result_low_byte;
      end
   end

   // Set wins over a simultaneous software clear
   always_comb begin
      next_converter_control_reg = converter_control_reg;
      if (ctrl_write) begin
         next_converter_control_reg = sfr_wdata_i;
      end
      if (window_hit) begin
         next_converter_control_reg[adc_window_pkg::CTRL_FLAG_BIT] =
            1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         converter_control_reg <= adc_window_pkg::CTRL_RESET;
      end else begin
         converter_control_reg <= next_converter_control_reg;
      end
   end

   always_comb begin
      next_rdata = sfr_rdata_o;
      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            adc_window_pkg::ADDR_CTRL: next_rdata = converter_control_reg;
            adc_window_pkg::ADDR_RESULT_HIGH: next_rdata = result_high_byte;
            adc_window_pkg::ADDR_RESULT_LOW: next_rdata = result_low_byte;
            adc_window_pkg::ADDR_GREATER_HIGH:
               next_rdata = window_greater_high_byte;
            adc_window_pkg::ADDR_GREATER_LOW:
               next_rdata = window_greater_low_byte;
            adc_window_pkg::ADDR_LESS_HIGH:
               next_rdata = window_less_high_byte;
            adc_window_pkg::ADDR_LESS_LOW:
               next_rdata = window_less_low_byte;
            default: next_rdata = adc_window_pkg::UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sfr_rdata_o <= adc_window_pkg::UNMAPPED_READ;
      end else begin
         sfr_rdata_o <= next_rdata;
      end
   end

   always_comb begin
      window_compare_flag_o =
         converter_control_reg[adc_window_pkg::CTRL_FLAG_BIT];
      result_left_justify_o =
         converter_control_reg[adc_window_pkg::CTRL_LJUST_BIT];
   end
endmodule

// file: testbench/adc_result_window_detect_monitor.sv
`timescale 1ns/1ps
module adc_result_window_detect_monitor (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic result_valid_i,
   input wire logic [adc_window_pkg::RESULT_W-1:0] result_data_i,
   input wire logic differential_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic window_compare_flag_o,
   input wire logic result_left_justify_o
);
   logic ctl_wr;
   assign ctl_wr = sfr_wr_i && sfr_addr_i == adc_window_pkg::ADDR_CTRL;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   a_flag_holds: assert property (window_compare_flag_o &&
      !(ctl_wr && !sfr_wdata_i[1]) |=> window_compare_flag_o) else $error("flag lost");
   a_flag_cause: assert property ($rose(window_compare_flag_o) |->
      $past(result_valid_i || ctl_wr && sfr_wdata_i[1])) else $error("flag no cause");
   a_flag_sw_set: assert property (ctl_wr && sfr_wdata_i[1] |=>
      window_compare_flag_o) else $error("flag not set");
   a_ljust_follows: assert property (ctl_wr |=>
      result_left_justify_o == $past(sfr_wdata_i[0])) else $error("justify wrong");
   a_ljust_stable: assert property (!ctl_wr |=>
      $stable(result_left_justify_o)) else $error("justify moved");
   a_rdata_holds: assert property (!sfr_rd_i |=>
      $stable(sfr_rdata_o)) else $error("read data moved");
   a_gt_low_rw: assert property (sfr_wr_i && sfr_addr_i ==
      adc_window_pkg::ADDR_GREATER_LOW ##1 !sfr_wr_i ##1 sfr_rd_i && !sfr_wr_i
      && sfr_addr_i == adc_window_pkg::ADDR_GREATER_LOW
      |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("low byte lost");
   a_low_byte_fmt: assert property (result_valid_i ##1 !result_valid_i
      && !sfr_wr_i ##1 sfr_rd_i && !sfr_wr_i && !result_valid_i &&
      sfr_addr_i == adc_window_pkg::ADDR_RESULT_LOW |=> sfr_rdata_o ==
      ($past(result_left_justify_o, 3) ? {$past(result_data_i[1:0], 3),
      6'h00} : $past(result_data_i[7:0], 3))) else $error("low byte wrong");
endmodule
bind adc_result_window_detect adc_result_window_detect_monitor mon (.clk_i,
   .srst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .result_valid_i,
   .result_data_i, .differential_i, .sfr_rdata_o, .window_compare_flag_o,
   .result_left_justify_o);

// file: testbench/adc_result_window_detect_tb.sv
`timescale 1ns/1ps
module adc_result_window_detect_tb;
   logic clk_i = 1'b0, srst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
   logic result_valid_i = 1'b0, differential_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic [9:0] result_data_i = 10'h000;
   logic window_compare_flag_o, result_left_justify_o;
   int failures = 0;
   int checked = 0;
   always #25 clk_i = ~clk_i;
   adc_result_window_detect dut (.clk_i, .srst_i, .sfr_addr_i, .sfr_wr_i,
      .sfr_rd_i, .sfr_wdata_i, .result_valid_i, .result_data_i,
      .differential_i, .sfr_rdata_o, .window_compare_flag_o,
      .result_left_justify_o);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: %h vs %h", $time, got, exp);
         failures++;
      end
   endtask
   task end_of_test;
      if (failures == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge clk_i);
      sfr_rd_i <= 1'b0;
      #1 chk(sfr_rdata_o, e);
   endtask
   // Flag is checked right after every result since it is sticky
   task res(input logic d, input logic [9:0] v, input logic f);
      @(posedge clk_i);
      result_data_i <= v;
      differential_i <= d;
      result_valid_i <= 1'b1;
      @(posedge clk_i);
      result_valid_i <= 1'b0;
      #1 chk({7'h00, window_compare_flag_o}, {7'h00, f});
   endtask
   task limits(input logic [15:0] gt, input logic [15:0] lt);
      wr(8'hC5, gt[15:8]);
      wr(8'hC4, gt[7:0]);
      wr(8'hC7, lt[15:8]);
      wr(8'hC6, lt[7:0]);
   endtask
   task fmt(input logic j, d, input logic [9:0] v, input logic [7:0] h, l);
      wr(8'hE8, {7'h00, j});
      res(d, v, 1'b0);
      chk({7'h00, result_left_justify_o}, {7'h00, j});
      rd(8'hBE, l);
      rd(8'hBF, h);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(8'hC4, 8'hFF);
      rd(8'h00, 8'h00);
      fmt(1'b0, 1'b0, 10'h3FF, 8'h03, 8'hFF);
      fmt(1'b1, 1'b0, 10'h200, 8'h80, 8'h00);
      fmt(1'b1, 1'b0, 10'h3FF, 8'hFF, 8'hC0);
      fmt(1'b0, 1'b1, 10'h3FF, 8'hFF, 8'hFF);
      fmt(1'b0, 1'b1, 10'h100, 8'h01, 8'h00);
      fmt(1'b1, 1'b1, 10'h300, 8'hC0, 8'h00);
      wr(8'hC4, 8'h5A);
      rd(8'hC4, 8'h5A);
      wr(8'hE8, 8'h00);
      limits(16'h0100, 16'h0300);
      res(1'b0, 10'h200, 1'b1);
      res(1'b0, 10'h050, 1'b1);
      rd(8'hE8, 8'h02);
      wr(8'hE8, 8'h00);
      res(1'b0, 10'h300, 1'b0);
      limits(16'h0300, 16'h0100);
      res(1'b0, 10'h050, 1'b1);
      wr(8'hE8, 8'h00);
      res(1'b0, 10'h200, 1'b0);
      wr(8'hE8, 8'h01);
      limits(16'h8000, 16'hFFC0);
      res(1'b0, 10'h3FE, 1'b1);
      wr(8'hE8, 8'h02);
      rd(8'hE8, 8'h02);
      // Mid-run reset must restore limits and clear the sticky flag
      @(posedge clk_i);
      srst_i <= 1'b1;
      @(posedge clk_i);
      srst_i <= 1'b0;
      rd(8'hC4, 8'hFF);
      rd(8'hE8, 8'h00);
      end_of_test;
   end
   initial begin
      #50000;
      failures++;
      end_of_test;
   end
endmodule
